// ==== src/uadt_top.sv ====
// uadt_top: UART decode and trigger engine with an AXI4-Lite register port.
// Assumes asynchronous line pins and a single-outstanding AXI4-Lite master.
// Function
// RULE_01 - Start bit is first logical zero
// RULE_02 - Stop bits and idle are logical one
// RULE_03 - Start, data, optional parity, stop bits
// RULE_04 - Data shifted LSB first, parity last
// RULE_05 - Sampling aligned to start-bit edge
// RULE_06 - Idle gap of set length splits frames
// RULE_07 - One polarity setting for both lines
// RULE_08 - Parity none, even or odd
// RULE_09 - One, one and half, two stops
// RULE_10 - Bit rate 150 to 39,062,500 bit/s
// RULE_11 - Data size five to nine bits
// RULE_12 - Receive line plus optional transmit source
// RULE_13 - Fire on start bit or frame start
// RULE_14 - Break: start without valid stop
// RULE_15 - Parity error and frame error modes
// RULE_16 - Fire on n-th symbol of frame
// RULE_17 - One to four symbols match pattern
// RULE_18 - Any single symbol matches pattern
// RULE_19 - Break on low beyond one symbol
// RULE_20 - Symbol offset ranges 0 to 4,095
// RULE_21 - Pattern bits zero, one or don't-care
// RULE_22 - Zero in stop position flags error
// RULE_23 - Mid-bit sampling from bit-rate divider
`timescale 1ns/1ns
`default_nettype none
module uadt_top
  import uadt_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic trig_o
);
  uadt_ctrl_s ctrl_reg;
  uadt_pcfg_s pcfg_reg;
  uadt_rxcfg_s rx_cfg;
  uadt_ev_s ev_rx, ev_tx, ev;
  logic [31:0] rate_reg, idle_reg, pval_reg, pmsk_reg, div_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg, rd_data;
  logic [3:0] wstrb_reg, sticky_reg, clr;
  logic aw_hold_reg, w_hold_reg, wr_go, wr_ok, rd_ok;
  logic [12:0] sidx_reg, win_lo, win_hi;
  logic [8:0] last_reg;
  logic pm_ok_reg, in_win, hit, cur_match;
  logic [1:0] pk;
  logic dv_busy_reg;
  logic [5:0] dv_cnt_reg;
  logic [31:0] dv_num_reg, dv_rem_reg, dv_quo_reg, dv_den_reg, dv_q;
  logic [32:0] dv_try;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Keep the bit rate inside its legal span
  function automatic logic [31:0] clamp_rate(input logic [31:0] r);
    if (r < RATE_MIN) return RATE_MIN;
    else if (r > RATE_MAX) return RATE_MAX;
    else return r;
  endfunction

  // Keep the data size inside five to nine bits
  function automatic uadt_ctrl_s fix_ctrl(input logic [31:0] w);
    uadt_ctrl_s c;
    c = uadt_ctrl_s'(w);
    c.rsvd = '0;
    if (c.size < SIZE_MIN) c.size = SIZE_MIN;
    if (c.size > SIZE_MAX) c.size = SIZE_MAX;
    if (c.par > P_ODD) c.par = P_NONE;
    if (c.stop > S_TWO) c.stop = S_ONE;
    return c;
  endfunction

  // Pattern test with per-bit care mask, cleared mask bits match anything
  function automatic logic sym_match(input logic [8:0] d, input logic [7:0] v,
                                     input logic [7:0] m);
    return ((d[7:0] ^ v) & m) == '0;
  endfunction

  // Write address channel and write data channel, taken in either order
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_reg <= 1'h0;
      s_axi_awready <= 1'h1;
      waddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'h1;
      s_axi_awready <= 1'h0;
      waddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_hold_reg <= 1'h0;
      s_axi_awready <= 1'h1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_hold_reg <= 1'h0;
      s_axi_wready <= 1'h1;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'h1;
      s_axi_wready <= 1'h0;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_hold_reg <= 1'h0;
      s_axi_wready <= 1'h1;
    end
  end

  // Write performed once both halves are held
  assign wr_go = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  assign wr_ok = (waddr_reg[ADDR_W-1:2] <= OFF_DIV[ADDR_W-1:2]) && (waddr_reg[1:0] == 2'h0);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'h1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'h0;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
      rate_reg <= RATE_DEF;
      idle_reg <= IDLE_DEF;
      pcfg_reg <= '0;
      pval_reg <= '0;
      pmsk_reg <= '0;
    end else if (wr_go) begin
      case (waddr_reg)
        // RULE_11 size clamped five to nine
        OFF_CTRL: ctrl_reg <= fix_ctrl(merge(ctrl_reg, wdata_reg, wstrb_reg));
        // RULE_10 rate span enforced
        OFF_RATE: rate_reg <= clamp_rate(merge(rate_reg, wdata_reg, wstrb_reg));
        OFF_IDLE: idle_reg <= merge(idle_reg, wdata_reg, wstrb_reg);
        // RULE_20 twelve-bit symbol offset
        OFF_PCFG: pcfg_reg <= uadt_pcfg_s'(merge(pcfg_reg, wdata_reg, wstrb_reg)
                              & {14'h0, 2'h3, 4'h0, 12'hFFF});
        OFF_PVAL: pval_reg <= merge(pval_reg, wdata_reg, wstrb_reg);
        OFF_PMSK: pmsk_reg <= merge(pmsk_reg, wdata_reg, wstrb_reg);
        default: ;
      endcase
    end
  end

  // Bits per second to clock cycles per bit, restoring division
  assign dv_try = {dv_rem_reg, dv_num_reg[31]} - {1'h0, dv_den_reg};
  assign dv_q = {dv_quo_reg[30:0], ~dv_try[32]};

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dv_busy_reg <= 1'h0;
      dv_cnt_reg <= '0;
      dv_num_reg <= '0;
      dv_rem_reg <= '0;
      dv_quo_reg <= '0;
      dv_den_reg <= RATE_DEF;
      div_reg <= DIV_DEF;
    end else if (wr_go && waddr_reg == OFF_RATE) begin
      dv_busy_reg <= 1'h1;
      dv_cnt_reg <= '0;
      dv_num_reg <= CLK_HZ;
      dv_rem_reg <= '0;
      dv_quo_reg <= '0;
      dv_den_reg <= clamp_rate(merge(rate_reg, wdata_reg, wstrb_reg));
    end else if (dv_busy_reg) begin
      dv_num_reg <= dv_num_reg << 1;
      dv_rem_reg <= dv_try[32] ? {dv_rem_reg[30:0], dv_num_reg[31]} : dv_try[31:0];
      dv_quo_reg <= dv_q;
      dv_cnt_reg <= dv_cnt_reg + 6'h1;
      // RULE_23 divider loaded from rate
      if (dv_cnt_reg == DV_LAST) begin
        dv_busy_reg <= 1'h0;
        div_reg <= (dv_q == '0) ? DIV_MIN : dv_q;
      end
    end
  end

  // Receiver settings shared by both lines
  // RULE_07 one polarity for both
  assign rx_cfg = '{pol_high: ctrl_reg.pol_high, par: ctrl_reg.par, stop: ctrl_reg.stop,
                    size: ctrl_reg.size, div: div_reg, idle: idle_reg};

  // RULE_12 receive and transmit decoders
  uadt_rx u_rx (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .en(1'h1),
    .line_pin(rx_pin),
    .cfg(rx_cfg),
    .ev(ev_rx)
  );

  uadt_rx u_tx (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .en(ctrl_reg.tx_en),
    .line_pin(tx_pin),
    .cfg(rx_cfg),
    .ev(ev_tx)
  );

  // RULE_12 trigger source select
  assign ev = (ctrl_reg.src_tx && ctrl_reg.tx_en) ? ev_tx : ev_rx;

  // RULE_06 symbol index within frame
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sidx_reg <= '0;
      last_reg <= '0;
    end else begin
      if (ev.start && ev.fstart) sidx_reg <= '0;
      else if (ev.sym && sidx_reg != SIDX_SAT) sidx_reg <= sidx_reg + 13'h1;
      if (ev.sym) last_reg <= ev.data;
    end
  end

  // Pattern window from offset over one to four symbols
  assign win_lo = {1'h0, pcfg_reg.offset};
  assign win_hi = win_lo + {11'h0, pcfg_reg.nsym_m1};
  assign in_win = (sidx_reg >= win_lo) && (sidx_reg <= win_hi);
  assign pk = 2'(sidx_reg - win_lo);
  // RULE_21 masked bit compare
  assign cur_match = sym_match(ev.data, pval_reg[pk*8 +: 8], pmsk_reg[pk*8 +: 8]);

  // RULE_17 running match over window
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) pm_ok_reg <= 1'h0;
    else if (ev.sym && in_win) pm_ok_reg <= (sidx_reg == win_lo) ? cur_match
                                            : (pm_ok_reg & cur_match);
  end

  // Trigger condition by mode
  always_comb begin
    hit = 1'h0;
    case (ctrl_reg.mode)
      // RULE_13 every start bit
      M_START: hit = ev.start;
      // RULE_13 first start after gap
      M_FSTART: hit = ev.start & ev.fstart;
      // RULE_15 frame error mode
      // RULE_22 stop sampled low
      M_FERR: hit = ev.sym & ev.ferr;
      // RULE_16 selected symbol position
      M_SYMN: hit = ev.sym & (sidx_reg == win_lo);
      // RULE_14 start without stop
      M_BREAK: hit = ev.sym & ev.brk;
      // RULE_15 parity disagreement
      M_PERR: hit = ev.sym & ev.perr;
      // RULE_17 last symbol of window
      M_PATT: hit = ev.sym & (sidx_reg == win_hi) & cur_match
                    & ((sidx_reg == win_lo) | pm_ok_reg);
      // RULE_18 any single symbol
      M_ANY: hit = ev.sym & sym_match(ev.data, pval_reg[7:0], pmsk_reg[7:0]);
      default: hit = 1'h0;
    endcase
  end

  // Trigger output pulse
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) trig_o <= 1'h0;
    else trig_o <= hit;
  end

  // Sticky event flags, write one to clear, a new event wins
  assign clr = (wr_go && waddr_reg == OFF_STAT && wstrb_reg[0]) ? wdata_reg[3:0] : '0;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) sticky_reg <= '0;
    else sticky_reg <= (sticky_reg & ~clr) | {ev.sym & ev.brk, ev.sym & ev.ferr,
                                              ev.sym & ev.perr, hit};
  end

  // Read decode
  always_comb begin
    rd_data = '0;
    rd_ok = 1'h1;
    case (s_axi_araddr)
      OFF_CTRL: rd_data = ctrl_reg;
      OFF_RATE: rd_data = rate_reg;
      OFF_IDLE: rd_data = idle_reg;
      OFF_PCFG: rd_data = pcfg_reg;
      OFF_PVAL: rd_data = pval_reg;
      OFF_PMSK: rd_data = pmsk_reg;
      OFF_STAT: rd_data = uadt_stat_s'{rsvd: '0, sidx: sidx_reg, last: last_reg,
                                       sticky: sticky_reg};
      OFF_DIV: rd_data = div_reg;
      default: rd_ok = 1'h0;
    endcase
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'h0;
      s_axi_arready <= 1'h1;
    end
  end

endmodule
`default_nettype wire

// ==== src/uadt_pkg.sv ====
// uadt_pkg: constants, register map and carrier types of the UART decode trigger.
// Assumes a 25 MHz core clock and a 32-bit AXI4-Lite register port.
package uadt_pkg;
  // Clock and bit rate limits
  localparam logic [31:0] CLK_HZ = 32'h017D7840;
  localparam logic [31:0] RATE_MIN = 32'h00000096;
  localparam logic [31:0] RATE_MAX = 32'h02540BE4;
  localparam logic [31:0] RATE_DEF = 32'h00002580;
  localparam logic [31:0] DIV_DEF = CLK_HZ / RATE_DEF;
  localparam logic [31:0] DIV_MIN = 32'h00000001;
  localparam logic [5:0] DV_LAST = 6'h1F;
  localparam logic [31:0] IDLE_DEF = 32'h00002710;
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RATE = 8'h04;
  localparam logic [7:0] OFF_IDLE = 8'h08;
  localparam logic [7:0] OFF_PCFG = 8'h0C;
  localparam logic [7:0] OFF_PVAL = 8'h10;
  localparam logic [7:0] OFF_PMSK = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_DIV = 8'h1C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Data size limits
  localparam logic [3:0] SIZE_MIN = 4'h5;
  localparam logic [3:0] SIZE_MAX = 4'h9;
  localparam logic [3:0] SIZE_DEF = 4'h8;
  localparam logic [12:0] SIDX_SAT = 13'h1FFF;

  typedef enum logic [2:0] {
    M_START = 3'h0, M_FSTART = 3'h1, M_FERR = 3'h2, M_SYMN = 3'h3,
    M_BREAK = 3'h4, M_PERR = 3'h5, M_PATT = 3'h6, M_ANY = 3'h7
  } uadt_mode_e;
  typedef enum logic [1:0] {P_NONE = 2'h0, P_EVEN = 2'h1, P_ODD = 2'h2} uadt_par_e;
  typedef enum logic [1:0] {S_ONE = 2'h0, S_ONE_HALF = 2'h1, S_TWO = 2'h2} uadt_stop_e;

  // Control register layout
  typedef struct packed {
    logic [17:0] rsvd;
    uadt_mode_e mode;
    logic [3:0] size;
    uadt_stop_e stop;
    uadt_par_e par;
    logic tx_en;
    logic src_tx;
    logic pol_high;
  } uadt_ctrl_s;
  localparam uadt_ctrl_s CTRL_RST = '{rsvd: '0, mode: M_START, size: SIZE_DEF,
    stop: S_ONE, par: P_NONE, tx_en: 1'h0, src_tx: 1'h0, pol_high: 1'h1};

  // Pattern position register layout
  typedef struct packed {
    logic [13:0] rsvd;
    logic [1:0] nsym_m1;
    logic [3:0] rsvd2;
    logic [11:0] offset;
  } uadt_pcfg_s;

  // Status register layout
  typedef struct packed {
    logic [5:0] rsvd;
    logic [12:0] sidx;
    logic [8:0] last;
    logic [3:0] sticky;
  } uadt_stat_s;

  // Receiver configuration and events
  typedef struct packed {
    logic pol_high;
    uadt_par_e par;
    uadt_stop_e stop;
    logic [3:0] size;
    logic [31:0] div;
    logic [31:0] idle;
  } uadt_rxcfg_s;
  typedef struct packed {
    logic start;
    logic fstart;
    logic sym;
    logic perr;
    logic ferr;
    logic brk;
    logic [8:0] data;
  } uadt_ev_s;
endpackage

// ==== src/uadt_rx.sv ====
// uadt_rx: recovers UART symbols from one line and reports them as pulses.
// Assumes a pin-level input and configuration steady while a symbol runs.
`timescale 1ns/1ns
`default_nettype none
module uadt_rx
  import uadt_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic en,
  input wire logic line_pin,
  input wire uadt_rxcfg_s cfg,
  output uadt_ev_s ev
);
  typedef enum logic [2:0] {
    R_IDLE = 3'h0, R_START = 3'h1, R_DATA = 3'h2, R_PAR = 3'h3, R_STOP = 3'h4
  } uadt_rst_e;
  uadt_rst_e st_reg;
  logic s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [31:0] hc_reg, half, idle_reg;
  logic [2:0] ht_reg;
  logic [3:0] idx_reg;
  logic [8:0] sh_reg;
  logic par_reg, bad_reg, low_reg, armed_reg, gap_reg, bit_v, tick;

  // Three-stage synchroniser, level taken when stages two and three agree
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= 1'h1;
      s2_reg <= 1'h1;
      s3_reg <= 1'h1;
      lvl_reg <= 1'h1;
    end else begin
      s1_reg <= line_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) lvl_reg <= s3_reg;
    end
  end

  // RULE_07 polarity to logic
  assign bit_v = cfg.pol_high ? lvl_reg : ~lvl_reg;
  // RULE_23 half-bit ticks from divider
  assign half = (cfg.div >> 1) == '0 ? DIV_MIN : (cfg.div >> 1);
  assign tick = (hc_reg >= half - DIV_MIN);

  // Half-bit divider, restarted at the start-bit edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) hc_reg <= '0;
    else if (st_reg == R_IDLE || tick) hc_reg <= '0;
    else hc_reg <= hc_reg + DIV_MIN;
  end

  // RULE_06 idle gap counter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) idle_reg <= '1;
    else if (st_reg != R_IDLE) idle_reg <= '0;
    else if (bit_v && idle_reg != '1) idle_reg <= idle_reg + DIV_MIN;
  end

  // Symbol state machine
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= R_IDLE;
      ht_reg <= '0;
      idx_reg <= '0;
      sh_reg <= '0;
      par_reg <= 1'h0;
      bad_reg <= 1'h0;
      low_reg <= 1'h0;
      armed_reg <= 1'h0;
      gap_reg <= 1'h0;
      ev <= '0;
    end else begin
      ev <= '0;
      if (!en) begin
        st_reg <= R_IDLE;
        armed_reg <= 1'h0;
      end else begin
        case (st_reg)
          R_IDLE: begin
            ht_reg <= '0;
            if (bit_v) armed_reg <= 1'h1;
            // RULE_01 first zero after one
            // RULE_05 align to start edge
            if (!bit_v && armed_reg) begin
              st_reg <= R_START;
              gap_reg <= (idle_reg >= cfg.idle);
            end
          end
          R_START: begin
            if (tick) begin
              if (!bit_v) begin
                ev.start <= 1'h1;
                ev.fstart <= gap_reg;
                st_reg <= R_DATA;
                idx_reg <= '0;
                sh_reg <= '0;
                low_reg <= 1'h1;
                bad_reg <= 1'h0;
              end else begin
                st_reg <= R_IDLE;
              end
            end
          end
          R_DATA: begin
            if (tick) begin
              if (ht_reg == 3'h1) begin
                // RULE_04 data bits LSB first
                sh_reg[idx_reg] <= bit_v;
                low_reg <= low_reg & ~bit_v;
                ht_reg <= '0;
                idx_reg <= idx_reg + 4'h1;
                // RULE_03 parity only when enabled
                if (idx_reg == cfg.size - 4'h1) st_reg <= (cfg.par != P_NONE) ? R_PAR : R_STOP;
              end else begin
                ht_reg <= ht_reg + 3'h1;
              end
            end
          end
          R_PAR: begin
            if (tick) begin
              if (ht_reg == 3'h1) begin
                par_reg <= bit_v;
                low_reg <= low_reg & ~bit_v;
                ht_reg <= '0;
                st_reg <= R_STOP;
              end else begin
                ht_reg <= ht_reg + 3'h1;
              end
            end
          end
          R_STOP: begin
            if (tick) begin
              ht_reg <= ht_reg + 3'h1;
              // RULE_02 stop must be one
              // RULE_22 zero at stop is error
              if ((ht_reg == 3'h1 || (ht_reg == 3'h3 && cfg.stop == S_TWO)) && !bit_v)
                bad_reg <= 1'h1;
              // RULE_09 stop length in half bits
              if (ht_reg == 3'h2 + {1'h0, cfg.stop}) begin
                ev.sym <= 1'h1;
                ev.data <= sh_reg;
                // RULE_08 even or odd check
                ev.perr <= (cfg.par != P_NONE) & (^sh_reg ^ par_reg ^ (cfg.par == P_ODD));
                ev.ferr <= bad_reg;
                // RULE_19 low across whole symbol
                ev.brk <= bad_reg & low_reg;
                armed_reg <= 1'h0;
                st_reg <= R_IDLE;
              end
            end
          end
          default: st_reg <= R_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/uadt_uart_model.sv ====
// uadt_uart_model: behavioural asynchronous transmitter for one line.
// Assumes the bench calls its tasks just after a rising core_clk edge.
`timescale 1ns/1ns
`default_nettype none
module uadt_uart_model #(
  parameter int DIV = 25
) (
  input wire logic core_clk,
  output var logic line
);
  logic pol = 1'b1;
  initial line = 1'b1;
  // Drives one logical level for a number of cycles
  task automatic drive(input logic b, input int cyc);
    line <= pol ? b : ~b;
    repeat (cyc) @(posedge core_clk);
  endtask
  task automatic set_pol(input logic p);
    pol = p;
    line <= p;
  endtask
  task automatic send(input logic [8:0] d, input int n, input logic [1:0] par,
                      input int halves, input logic bad_par, input logic bad_stop);
    drive(1'b0, DIV);
    for (int i = 0; i < n; i++) drive(d[i], DIV);
    if (par != 2'h0) drive((par == 2'h2) ^ (^d) ^ bad_par, DIV);
    drive(~bad_stop, halves * DIV / 2);
    if (bad_stop) drive(1'b1, DIV);
  endtask
  // line low far beyond one symbol
  task automatic brk();
    drive(1'b0, 15 * DIV);
    drive(1'b1, DIV);
  endtask
endmodule
`default_nettype wire

// ==== bench/uadt_top_properties.sv ====
// uadt_top_properties: bus handshake and trigger pulse checks.
// Assumes binding to uadt_top with ports of the same names.
`timescale 1ns/1ns
`default_nettype none
module uadt_top_props
  import uadt_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trig_o
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Handshake timing and holding
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write answer dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read answer dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read ok");
  trig_pulse_a: assert property (trig_o |=> !trig_o) else $error("trigger too long");
  // Main scenarios
  cover property (trig_o);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_OKAY);
endmodule
bind uadt_top uadt_top_props u_props (.*);
`default_nettype wire

// ==== bench/uadt_top_test.sv ====
// uadt_top_test: register and line level bench of the UART decode trigger.
// Assumes two line models and an AXI4-Lite master in this module.
`timescale 1ns/1ns
`default_nettype none
module uadt_top_test
  import uadt_pkg::*;
;
  localparam int BIT = 25;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rx_pin, tx_pin;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, trig_clr = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, trig_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [31:0] trig_cnt = '0;
  int error_cnt = 0, tests_run = 0;
  uadt_ctrl_s c;
  logic [7:0] ra [5] = '{OFF_CTRL, OFF_RATE, OFF_IDLE, OFF_DIV, 8'h20};
  logic [33:0] re [5] = '{{RESP_OKAY, CTRL_RST}, {RESP_OKAY, RATE_DEF},
    {RESP_OKAY, IDLE_DEF}, {RESP_OKAY, DIV_DEF}, {RESP_SLVERR, 32'h0}};
  int exp_n [8] = '{5, 1, 2, 1, 1, 1, 1, 1};
  uadt_top DUT (.*);
  uadt_uart_model #(.DIV(BIT)) rx_m (.core_clk(core_clk), .line(rx_pin));
  uadt_uart_model #(.DIV(BIT)) tx_m (.core_clk(core_clk), .line(tx_pin));
  // Clock and trigger pulse counter
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) trig_cnt <= trig_clr ? '0 : trig_cnt + 32'(trig_o === 1'b1);
  // Compares one value
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus write, waits for the answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 100) chk("write wait", 34'h1, 34'h0);
    @(posedge core_clk);
  endtask
  // Bus read, waits for the answer
  task automatic axi_rd(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 100) chk("read wait", 34'h1, 34'h0);
    @(posedge core_clk);
  endtask
  // One frame: good, good, bad parity, bad stop, then a break
  task automatic frame();
    trig_clr <= 1'b1;
    repeat (200) @(posedge core_clk);
    trig_clr <= 1'b0;
    rx_m.send(9'h011, 8, 2'h1, 2, 1'b0, 1'b0);
    rx_m.send(9'h022, 8, 2'h1, 2, 1'b0, 1'b0);
    rx_m.send(9'h033, 8, 2'h1, 2, 1'b1, 1'b0);
    rx_m.send(9'h044, 8, 2'h1, 2, 1'b0, 1'b1);
    rx_m.brk();
    repeat (3 * BIT) @(posedge core_clk);
  endtask
  // Verdict
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (90000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      axi_rd(ra[i]);
      chk("reset read", {rs, rd}, re[i]);
    end
    axi_wr(OFF_RATE, 32'h000F4240);
    repeat (40) @(posedge core_clk);
    axi_wr(OFF_DIV, 32'h0);
    axi_rd(OFF_DIV);
    chk("divider", {rs, rd}, {RESP_OKAY, CLK_HZ / 32'h000F4240});
    axi_wr(8'h21, 32'h0);
    chk("unaligned write", rs, RESP_SLVERR);
    axi_wr(OFF_IDLE, 32'h00000064);
    axi_wr(OFF_PCFG, 32'h00000001);
    axi_wr(OFF_PVAL, 32'h00000020);
    axi_wr(OFF_PMSK, 32'h000000F0);
    $display("test registers done");
    for (int m = 0; m < 8; m++) begin
      c = CTRL_RST;
      c.par = P_EVEN;
      c.mode = uadt_mode_e'(m);
      axi_wr(OFF_STAT, 32'h0000000F);
      axi_wr(OFF_CTRL, c);
      frame();
      chk("trigger count", trig_cnt, exp_n[m]);
      axi_rd(OFF_STAT);
      chk("sticky flags", rd[3:0], 4'hF);
    end
    $display("test modes done");
    c = CTRL_RST;
    c.pol_high = 1'b0;
    c.src_tx = 1'b1;
    c.tx_en = 1'b1;
    c.par = P_ODD;
    c.stop = S_TWO;
    c.size = SIZE_MAX;
    axi_wr(OFF_CTRL, c);
    rx_m.set_pol(1'b0);
    tx_m.set_pol(1'b0);
    trig_clr <= 1'b1;
    repeat (600) @(posedge core_clk);
    axi_wr(OFF_STAT, 32'h0000000F);
    trig_clr <= 1'b0;
    rx_m.send(9'h0F0, 9, 2'h2, 4, 1'b0, 1'b0);
    repeat (3 * BIT) @(posedge core_clk);
    chk("receive ignored", trig_cnt, 34'h0);
    tx_m.send(9'h1A5, 9, 2'h2, 4, 1'b0, 1'b0);
    repeat (3 * BIT) @(posedge core_clk);
    chk("transmit trigger", trig_cnt, 34'h1);
    axi_rd(OFF_STAT);
    chk("last symbol", rd[12:0], {9'h1A5, 4'h1});
    $display("test wide symbol done");
    complete_run();
  end
endmodule
`default_nettype wire
